// ### common/pwc_cfg.svh
// constants for the wetting-pulse configuration bank
// Function
// R1 - pulse time code n gives (n+1)*64us
// R2 - bit 3 sets 15mA for inputs 18-23
// R3 - bit 2 sets 15mA for inputs 12-17
// R4 - bit 1 sets 15mA for inputs 6-11
// R5 - bit 0 sets 15mA for inputs 0-5
// R6 - one enable bit per input
// R7 - timing register at 1Fh, upper bits zero
// R8 - enable register at 20h, resets to zero
// R9 - threshold register at 21h, six 2-bit fields
// R10 - threshold codes 2V, 2.7V, 3V, 4V
// R11 - reserved bits ignore writes, read zero
// R12 - enabled inputs get group current for time
`ifndef PWC_CFG_SVH
`define PWC_CFG_SVH

// register addresses
`define PWC_ADDR_W 6
`define PWC_TIMING_ADDR 6'h1F
`define PWC_ENABLE_ADDR 6'h20
`define PWC_THRES_ADDR 6'h21

// field positions
`define PWC_TIME_MSB 6
`define PWC_TIME_LSB 4
`define PWC_CUR_MSB 3
`define PWC_THRES_MSB 11
`define PWC_GROUP_SIZE 6

// reset value of all three registers
`define PWC_RESET_VAL 24'h000000

// timing: one activation unit in microseconds, core clock rate
`define PWC_UNIT_US 64
`define PWC_CLK_MHZ 20
`define PWC_UNIT_CYC (`PWC_UNIT_US * `PWC_CLK_MHZ)

`endif

// ### common/pwc_pkg.sv
// types for the wetting-pulse configuration bank
package pwc_pkg;

  // pulse timer states, one-hot
  typedef enum logic [1:0] {
    PWC_IDLE = 2'b01,
    PWC_RUN = 2'b10
  } pwc_state_e;

  // comparator threshold codes
  typedef enum logic [1:0] {
    PWC_THR_2V0 = 2'h0,
    PWC_THR_2V7 = 2'h1,
    PWC_THR_3V0 = 2'h2,
    PWC_THR_4V0 = 2'h3
  } pwc_thres_e;

  typedef logic [23:0] pwc_word_t;

endpackage

// ### verif/pwc_config_bank_tb.sv
// self-checking bench for the pulse configuration bank
`timescale 1ns/1ps
`include "pwc_cfg.svh"
`define CHK(nm, e, g) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("BAD %s exp %h got %h", nm, e, g); \
  end \
end
module pwc_config_bank_tb import pwc_pkg::*;;
  localparam int UC = 4;
  logic clock_i;
  logic rst_i;
  logic pulse_start_i;
  logic [5:0] addr;
  logic wr;
  logic rd;
  logic [23:0] wdata;
  logic [23:0] rdata;
  logic active;
  logic done;
  pwc_word_t drive;
  pwc_word_t hc;
  logic [11:0] thr;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [31:0] seed;
  pwc_word_t m [3];
  pwc_word_t wmask [3] = '{24'h00007F, 24'hFFFFFF, 24'h000FFF};
  pwc_word_t got;

  pwc_host_model host (.clock_i(clock_i), .reg_addr_o(addr), .reg_wr_o(wr), .reg_rd_o(rd),
    .reg_wdata_o(wdata), .reg_rdata_i(rdata));

  pwc_config_bank #(.UNIT_CYCLES(UC), .NUM_INPUTS(24)) dut (.clock_i(clock_i), .rst_i(rst_i),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .pulse_start_i(pulse_start_i), .pulse_active_o(active), .pulse_done_o(done),
    .pulse_drive_o(drive), .pulse_high_current_o(hc), .threshold_sel_o(thr));

  // 20 MHz core clock
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  // hang guard
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      close_out();
    end
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // write through the host and track the expected register image
  task automatic wr_m(input int i, input pwc_word_t d);
    host.wr(6'(6'h1F + i), d);
    m[i] = d & wmask[i];
  endtask

  task automatic rd_c(input int i);
    host.rd(6'(6'h1F + i), got);
    `CHK("readback", m[i], got)
  endtask

  // one pulse: duration, done placement, drive and current per input
  task automatic run_pulse(input int t);
    int n;
    int dn;
    logic bad;
    pwc_word_t hx;
    n = 0;
    dn = -1;
    bad = 1'b0;
    for (int i = 0; i < 24; i++) hx[i] = m[1][i] & m[0][i / 6];
    @(posedge clock_i);
    pulse_start_i <= 1'b1;
    @(posedge clock_i);
    pulse_start_i <= 1'b0;
    #1;
    while (active === 1'b1 && n < 1000) begin
      n++;
      if (done === 1'b1) dn = (dn == -1) ? n : -2;
      if (drive !== m[1] || hc !== hx) bad = 1'b1;
      @(posedge clock_i);
      pulse_start_i <= (n == 2);
      #1;
    end
    `CHK("pulse length", (t + 1) * UC, n)
    `CHK("done cycle", (t + 1) * UC, dn)
    `CHK("drive and current", 1'b0, bad)
    @(posedge clock_i);
    #1;
    `CHK("idle after pulse", 50'h0, {active, done, drive, hc})
  endtask

  initial begin
    rst_i = 1'b1;
    pulse_start_i = 1'b0;
    seed = 32'h9297F467;
    for (int i = 0; i < 3; i++) m[i] = `PWC_RESET_VAL;
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    // reset values
    for (int i = 0; i < 3; i++) rd_c(i);
    `CHK("reset outputs", 36'h0, {thr, drive})
    $display("test reset values done");
    // reserved bits, then an unmapped address that must change nothing
    for (int i = 0; i < 3; i++) begin
      wr_m(i, 24'hFFFFFF);
      rd_c(i);
    end
    host.wr(6'h22, 24'h000000);
    host.rd(6'h22, got);
    `CHK("unmapped read", 24'h000000, got)
    for (int i = 0; i < 3; i++) rd_c(i);
    $display("test reserved and unmapped done");
    // every threshold code in every field
    for (int c = 0; c < 4; c++) begin
      wr_m(2, {12{c[1:0]}});
      `CHK("threshold out", {6{c[1:0]}}, thr)
    end
    $display("test threshold codes done");
    // random writes with full readback
    repeat (8) begin
      seed = lfsr_next(seed);
      wr_m(seed[31:30] % 3, seed[23:0]);
      for (int i = 0; i < 3; i++) rd_c(i);
      `CHK("threshold out", m[2][11:0], thr)
    end
    $display("test random readback done");
    // every activation time with random mask and group currents
    for (int c = 0; c < 8; c++) begin
      seed = lfsr_next(seed);
      wr_m(1, seed[23:0]);
      wr_m(0, {17'h00000, c[2:0], seed[27:24]});
      run_pulse(c);
    end
    $display("test pulses done");
    close_out();
  end
endmodule // pwc_config_bank_tb

// ### verif/pwc_host_model.sv
// host-side register access model for the pulse configuration bank
`timescale 1ns/1ps
`include "pwc_cfg.svh"
module pwc_host_model (
  // clock
  input wire logic clock_i,
  // register strobes toward the bank
  output logic [`PWC_ADDR_W-1:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [23:0] reg_wdata_o,
  // read data from the bank
  input wire logic [23:0] reg_rdata_i
);
  // idle bus at time zero
  initial begin
    reg_addr_o = 6'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 24'h000000;
  end

  // one-cycle write strobe; released lines show the inverse, not stale values
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    @(posedge clock_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge clock_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
    #1;
  endtask

  // one-cycle read strobe, data taken 1ns after the sampling edge
  task automatic rd(input logic [5:0] a, output logic [23:0] d);
    @(posedge clock_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge clock_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    #1;
    d = reg_rdata_i;
  endtask
endmodule // pwc_host_model

// ### verilog/pwc_config_bank.sv
// wetting-pulse configuration bank with its pulse controller
`timescale 1ns/1ps
`include "pwc_cfg.svh"
module pwc_config_bank
  import pwc_pkg::*;
#(
  parameter int unsigned UNIT_CYCLES = `PWC_UNIT_CYC,
  parameter int unsigned NUM_INPUTS = 24
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // register access from the serial interface
  input wire logic [`PWC_ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [23:0] reg_wdata_i,
  output logic [23:0] reg_rdata_o,
  // pulse sequencing
  input wire logic pulse_start_i,
  output logic pulse_active_o,
  output logic pulse_done_o,
  // to the current sources and comparator
  output logic [NUM_INPUTS-1:0] pulse_drive_o,
  output logic [NUM_INPUTS-1:0] pulse_high_current_o,
  output logic [`PWC_THRES_MSB:0] threshold_sel_o
);

  // stored fields
  logic [2:0] pulse_activation_time_reg, pulse_activation_time_next;
  logic [3:0] pulse_current_group_reg, pulse_current_group_next;
  logic [NUM_INPUTS-1:0] pulse_input_enable_mask_reg, pulse_input_enable_mask_next;
  logic [`PWC_THRES_MSB:0] comparator_threshold_select_reg;
  logic [`PWC_THRES_MSB:0] comparator_threshold_select_next;
  // read data
  pwc_word_t rdata_reg, rdata_next;
  // pulse snapshots
  logic [NUM_INPUTS-1:0] drive_reg, drive_next;
  logic [3:0] cur_snap_reg, cur_snap_next;
  // control
  logic timer_busy;
  logic timer_done;
  logic start_ok;

  // address decode and write of the three registers
  always_comb begin
    pulse_activation_time_next = pulse_activation_time_reg;
    pulse_current_group_next = pulse_current_group_reg;
    pulse_input_enable_mask_next = pulse_input_enable_mask_reg;
    comparator_threshold_select_next = comparator_threshold_select_reg;
    if (reg_wr_i) begin
      case (reg_addr_i)
        `PWC_TIMING_ADDR: begin // R7
          pulse_activation_time_next = reg_wdata_i[`PWC_TIME_MSB:`PWC_TIME_LSB]; // R1
          pulse_current_group_next = reg_wdata_i[`PWC_CUR_MSB:0]; // R2 R3 R4 R5
        end
        `PWC_ENABLE_ADDR: begin // R8
          pulse_input_enable_mask_next = reg_wdata_i[NUM_INPUTS-1:0]; // R6
        end
        `PWC_THRES_ADDR: begin // R9
          comparator_threshold_select_next = reg_wdata_i[`PWC_THRES_MSB:0]; // R10
        end
        default: begin
          pulse_activation_time_next = pulse_activation_time_reg;
        end
      endcase
    end
  end

  // read mux, reserved positions and unmapped addresses read zero
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `PWC_TIMING_ADDR: begin
          rdata_next = {17'h00000, pulse_activation_time_reg, pulse_current_group_reg}; // R11
        end
        `PWC_ENABLE_ADDR: begin
          rdata_next = 24'(pulse_input_enable_mask_reg);
        end
        `PWC_THRES_ADDR: begin
          rdata_next = {12'h000, comparator_threshold_select_reg}; // R11
        end
        default: begin
          rdata_next = 24'h000000;
        end
      endcase
    end
  end

  // pulse snapshot: mask and group currents held for the whole pulse
  always_comb begin
    start_ok = pulse_start_i && !timer_busy;
    drive_next = drive_reg;
    cur_snap_next = cur_snap_reg;
    if (start_ok) begin
      drive_next = pulse_input_enable_mask_reg; // R12
      cur_snap_next = pulse_current_group_reg;
    end else if (timer_done) begin
      drive_next = '0; // R6
    end
  end

  // register file and snapshot flip-flops
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pulse_activation_time_reg <= 3'h0; // R7
      pulse_current_group_reg <= 4'h0;
      pulse_input_enable_mask_reg <= '0; // R8
      comparator_threshold_select_reg <= 12'h000; // R9
      rdata_reg <= `PWC_RESET_VAL;
      drive_reg <= '0;
      cur_snap_reg <= 4'h0;
    end else begin
      pulse_activation_time_reg <= pulse_activation_time_next;
      pulse_current_group_reg <= pulse_current_group_next;
      pulse_input_enable_mask_reg <= pulse_input_enable_mask_next;
      comparator_threshold_select_reg <= comparator_threshold_select_next;
      rdata_reg <= rdata_next;
      drive_reg <= drive_next;
      cur_snap_reg <= cur_snap_next;
    end
  end

  // activation timer
  pwc_pulse_timer #(
    .UNIT_CYCLES(UNIT_CYCLES)
  ) u_timer (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .start_i(start_ok),
    .time_code_i(pulse_activation_time_reg),
    .busy_o(timer_busy),
    .done_o(timer_done)
  );

  // per-input current level from its six-input group
  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_cur
      assign pulse_high_current_o[gi] = drive_reg[gi] && cur_snap_reg[gi / `PWC_GROUP_SIZE]; // R2 R3 R4 R5 R12
    end
  endgenerate

  // outputs
  assign reg_rdata_o = rdata_reg;
  assign pulse_active_o = timer_busy;
  assign pulse_done_o = timer_done;
  assign pulse_drive_o = drive_reg; // R12
  assign threshold_sel_o = comparator_threshold_select_reg; // R10

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  // register bank: reset values, writes and readback
  reset_zero_a: assert property ($past(rst_i) |-> // R7
    pulse_activation_time_reg == 3'h0 && pulse_current_group_reg == 4'h0)
    else $error("timing register not zero after reset");
  mask_reset_a: assert property ($past(rst_i) |-> // R8
    pulse_input_enable_mask_reg == '0 && drive_reg == '0)
    else $error("enable mask not zero after reset");
  time_write_a: assert property (reg_wr_i && reg_addr_i == `PWC_TIMING_ADDR |=> // R1
    pulse_activation_time_reg == $past(reg_wdata_i[6:4]))
    else $error("time field not written");
  timing_rsvd_a: assert property (reg_rd_i && reg_addr_i == `PWC_TIMING_ADDR |=> // R11
    reg_rdata_o[23:7] == 17'h00000 && reg_rdata_o[6:0] ==
    {$past(pulse_activation_time_reg), $past(pulse_current_group_reg)})
    else $error("timing readback wrong");
  thres_read_a: assert property (reg_rd_i && reg_addr_i == `PWC_THRES_ADDR |=> // R9
    reg_rdata_o == {12'h000, $past(comparator_threshold_select_reg)})
    else $error("threshold readback wrong");
  thres_write_a: assert property (reg_wr_i && reg_addr_i == `PWC_THRES_ADDR |=> // R10
    threshold_sel_o == $past(reg_wdata_i[11:0]))
    else $error("threshold field not written");
  mask_write_a: assert property (reg_wr_i && reg_addr_i == `PWC_ENABLE_ADDR |=> // R6
    pulse_input_enable_mask_reg == $past(reg_wdata_i[NUM_INPUTS-1:0]))
    else $error("enable mask not written");
  // pulse drive: nothing outside a pulse, the mask inside it
  drive_idle_a: assert property (!pulse_active_o |-> pulse_drive_o == '0) // R6
    else $error("current driven outside a pulse");
  drive_start_a: assert property (start_ok |=> // R12
    pulse_active_o && pulse_drive_o == $past(pulse_input_enable_mask_reg))
    else $error("pulse did not drive enabled inputs");
  // group current: each six-input group follows its own current bit
  grp_top_a: assert property (pulse_active_o |-> // R2
    pulse_high_current_o[23:18] == (pulse_drive_o[23:18] & {6{cur_snap_reg[3]}}))
    else $error("group 3 current wrong");
  grp_mid_a: assert property (pulse_active_o |-> // R3
    pulse_high_current_o[17:12] == (pulse_drive_o[17:12] & {6{cur_snap_reg[2]}}))
    else $error("group 2 current wrong");
  grp_low_a: assert property (pulse_active_o |-> // R4
    pulse_high_current_o[11:6] == (pulse_drive_o[11:6] & {6{cur_snap_reg[1]}}))
    else $error("group 1 current wrong");
  grp_base_a: assert property (pulse_active_o |-> // R5
    pulse_high_current_o[5:0] == (pulse_drive_o[5:0] & {6{cur_snap_reg[0]}}))
    else $error("group 0 current wrong");

  // unmapped addresses neither answer with data nor store anything
  logic addr_unmapped;
  assign addr_unmapped = (reg_addr_i != `PWC_TIMING_ADDR) &&
    (reg_addr_i != `PWC_ENABLE_ADDR) && (reg_addr_i != `PWC_THRES_ADDR);
  unmapped_read_a: assert property (reg_rd_i && addr_unmapped |=> // R11
    reg_rdata_o == 24'h000000)
    else $error("unmapped address read not zero");
  unmapped_write_a: assert property (reg_wr_i && addr_unmapped |=> // R11
    $stable(pulse_activation_time_reg) && $stable(pulse_current_group_reg) &&
    $stable(pulse_input_enable_mask_reg) && $stable(comparator_threshold_select_reg))
    else $error("unmapped address write changed a register");
  mask_read_a: assert property (reg_rd_i && reg_addr_i == `PWC_ENABLE_ADDR |=> // R8
    reg_rdata_o == 24'($past(pulse_input_enable_mask_reg)))
    else $error("enable mask readback wrong");

  // pulse shape: high current only where driven, snapshot frozen while running
  hicur_driven_a: assert property ((pulse_high_current_o & ~pulse_drive_o) == '0) // R12
    else $error("high current on an undriven input");
  snap_hold_a: assert property (pulse_active_o && !pulse_done_o |=> // R12
    $stable(pulse_drive_o) && $stable(cur_snap_reg))
    else $error("pulse settings changed during a pulse");

  // main scenarios
  cover_pulse: cover property (start_ok ##1 pulse_active_o);
  cover_unmapped: cover property (reg_rd_i && addr_unmapped);
  cover_high_cur: cover property (pulse_active_o && pulse_high_current_o != '0);
  cover_thres_max: cover property (threshold_sel_o == 12'hFFF);

endmodule // pwc_config_bank

// ### verilog/pwc_pulse_timer.sv
// activation timer for one wetting pulse
`timescale 1ns/1ps
`include "pwc_cfg.svh"
module pwc_pulse_timer
  import pwc_pkg::*;
#(
  parameter int unsigned UNIT_CYCLES = `PWC_UNIT_CYC
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // request
  input wire logic start_i,
  input wire logic [2:0] time_code_i,
  // status
  output logic busy_o,
  output logic done_o
);

  localparam logic [15:0] UNIT_LAST = 16'(UNIT_CYCLES - 1);

  pwc_state_e state_reg, state_next;
  logic [15:0] pre_reg, pre_next;
  logic [2:0] units_reg, units_next;
  logic [2:0] code_reg, code_next;
  logic unit_tick;

  // prescaler gives one unit tick per 64us, units counted to the code
  always_comb begin
    unit_tick = (state_reg == PWC_RUN) && (pre_reg == UNIT_LAST);
    done_o = unit_tick && (units_reg == code_reg); // R1
    state_next = state_reg;
    pre_next = pre_reg;
    units_next = units_reg;
    code_next = code_reg;
    case (state_reg)
      PWC_IDLE: begin
        if (start_i) begin
          state_next = PWC_RUN;
          pre_next = 16'h0000;
          units_next = 3'h0;
          code_next = time_code_i; // R1
        end
      end
      PWC_RUN: begin
        pre_next = unit_tick ? 16'h0000 : pre_reg + 16'h0001;
        if (done_o) begin
          state_next = PWC_IDLE;
        end else if (unit_tick) begin
          units_next = units_reg + 3'h1;
        end
      end
      default: begin
        state_next = PWC_IDLE;
      end
    endcase
  end

  // timer state registers
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= PWC_IDLE;
      pre_reg <= 16'h0000;
      units_reg <= 3'h0;
      code_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      pre_reg <= pre_next;
      units_reg <= units_next;
      code_reg <= code_next;
    end
  end

  assign busy_o = (state_reg == PWC_RUN);

  // helper: length of the current pulse
  logic [15:0] len_reg;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      len_reg <= 16'h0000;
    end else begin
      len_reg <= busy_o ? len_reg + 16'h0001 : 16'h0000;
    end
  end

  pulse_length_a: assert property (@(posedge clock_i) disable iff (rst_i) // R1
    $fell(busy_o) |-> len_reg == 16'((32'(code_reg) + 1) * UNIT_CYCLES))
    else $error("pulse length does not match time code");
  start_ignored_a: assert property (@(posedge clock_i) disable iff (rst_i) // R1
    busy_o && !done_o |=> busy_o && $stable(code_reg))
    else $error("time code changed during a pulse");
  cover_long_pulse: cover property (@(posedge clock_i) disable iff (rst_i)
    $fell(busy_o) && code_reg == 3'h7);

endmodule // pwc_pulse_timer
